// *** src/pmcap_defines.svh ***
// Offsets, field positions, reset values and fixed codes of the capability report
`ifndef PMCAP_DEFINES_SVH
`define PMCAP_DEFINES_SVH

// Configuration-space offset of the capability report (byte offset as printed)
`define PMCAP_REPORT_OFFSET      8'h46
// Value of the report after reset
`define PMCAP_REPORT_RESET       16'h6411

// Field positions inside the report
`define PMCAP_BIT_WAKE_COLD      15
`define PMCAP_BIT_WAKE_HOT       14
`define PMCAP_BIT_WAKE_D2        13
`define PMCAP_BIT_STATE_TWO      10
`define PMCAP_BIT_STATE_ONE      9
`define PMCAP_BIT_DYN_REPORT     8
`define PMCAP_BIT_DEV_INIT       5
`define PMCAP_BIT_AUX_SUPPLY     4
`define PMCAP_BIT_BUS_CLOCK      3

// Source bit positions in the miscellaneous configuration register
`define PMCAP_MISC_WAKE_COLD     15
`define PMCAP_MISC_WAKE_D2       13
`define PMCAP_MISC_STATE_TWO     10

// Reset values of the updatable bits
`define PMCAP_RST_WAKE_COLD      1'b0
`define PMCAP_RST_WAKE_D2        1'b1
`define PMCAP_RST_STATE_TWO      1'b1

// Fixed codes
`define PMCAP_WAKE_STATES_DFLT   4'hc
`define PMCAP_WAKE_HOT_FIXED     1'b1
`define PMCAP_WAKE_LOW_FIXED     2'h0
`define PMCAP_STATE_ONE_FIXED    1'b0
`define PMCAP_DYN_REPORT_FIXED   1'b0
`define PMCAP_RSVD_FIXED         2'h0
`define PMCAP_DEV_INIT_FIXED     1'b0
`define PMCAP_AUX_SUPPLY_FIXED   1'b1
`define PMCAP_BUS_CLOCK_FIXED    1'b0
`define PMCAP_REVISION_FIXED     3'h1

// Read data for an unmapped offset
`define PMCAP_UNMAPPED_DATA      16'h0000

`endif

// *** src/pmcap_pkg.sv ***
// Types shared by the capability report and its configuration port
package pmcap_pkg;

   // Configuration access from the host side
   typedef struct packed {
      logic [7:0]  addr;   // Byte offset in configuration space
      logic [15:0] wdata;  // Write data
      logic        wr;     // Write strobe, one cycle
      logic        rd;     // Read strobe, one cycle
   } pmcap_req_t;

   // Field layout of the capability report
   typedef struct packed {
      logic       wake_from_cold_capable;     // Bit 15
      logic [3:0] wake_source_states;         // Bits 14..11
      logic       state_two_supported;        // Bit 10
      logic       state_one_supported;        // Bit 9
      logic       dynamic_power_report;       // Bit 8
      logic [1:0] reserved;                   // Bits 7..6
      logic       device_init_needed;         // Bit 5
      logic       auxiliary_supply_needed;    // Bit 4
      logic       wake_needs_bus_clock;       // Bit 3
      logic [2:0] power_interface_revision;   // Bits 2..0
   } pmcap_caps_t;

endpackage

// *** src/pmcap_cfg_port.sv ***
// Configuration read port: offset decode and registered read data
`timescale 1ns/1ps
`include "pmcap_defines.svh"

module pmcap_cfg_port #(
   parameter int         ADDR_W = 8,
   parameter int         DATA_W = 16,
   parameter [ADDR_W-1:0] OFFSET = `PMCAP_REPORT_OFFSET
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic              rd,
   input  wire logic              wr,
   input  wire logic [DATA_W-1:0] reg_value,
   output logic                   hit_wr,
   output logic [DATA_W-1:0]      rdata
);

   logic [DATA_W-1:0] rdata_q;   // Read data, valid one cycle after the strobe

   // Decode of the one mapped offset
   function automatic logic offset_hit(input logic [ADDR_W-1:0] a);
      return a == OFFSET;
   endfunction

   // Write to the report, flagged so the owner can ignore it
   assign hit_wr = wr && offset_hit(addr);

   // Read data stand only in the cycle after the read strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= '0;
      end else if (rd && offset_hit(addr)) begin
         rdata_q <= reg_value;
      end else begin
         // Unmapped offset or idle cycle reads as zero
         rdata_q <= DATA_W'(`PMCAP_UNMAPPED_DATA);
      end
   end

   assign rdata = rdata_q;

endmodule

// *** src/pmcap_report.sv ***
// Power-management capability report with its configuration read port
`timescale 1ns/1ps
`include "pmcap_defines.svh"

module pmcap_report (
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire pmcap_pkg::pmcap_req_t  cfg_req,
   output logic [15:0]              cfg_rdata,
   input  wire logic [15:0]         misc_cfg,
   input  wire logic                misc_update,
   output pmcap_pkg::pmcap_caps_t   caps,
   output logic                     write_ignored
);
   import pmcap_pkg::*;

   // Updatable capability bits, mirrored from the misc register
   logic        wake_cold_q;         // Wake from cold-off capable
   logic        wake_cold_d;         // Next value
   logic        wake_d2_q;           // Wake from state two enabled
   logic        wake_d2_d;           // Next value
   logic        state_two_q;         // State two supported
   logic        state_two_d;         // Next value

   // Assembled report and its flat form
   pmcap_caps_t caps_w;              // Report fields
   logic [15:0] caps_flat;           // Report as read by the host

   // Write decode from the port
   logic        hit_wr;              // Host write to the report offset
   logic        write_ignored_q;     // Registered notice of a dropped write

   // Helper state for checks only
   logic        loaded_q;            // A misc update has been taken
   logic        rd_hit;              // Read strobe at the report offset
   logic        wr_hit;              // Write strobe at the report offset

   // Next values of the mirrored bits
   always_comb begin
      wake_cold_d = wake_cold_q;
      wake_d2_d   = wake_d2_q;
      state_two_d = state_two_q;
      // Misc register loaded from EEPROM or rewritten by the host
      if (misc_update) begin
         wake_cold_d = misc_cfg[`PMCAP_MISC_WAKE_COLD];
         wake_d2_d   = misc_cfg[`PMCAP_MISC_WAKE_D2];
         state_two_d = misc_cfg[`PMCAP_MISC_STATE_TWO];
      end
   end

   // Mirror flip-flops; the host write path never reaches them
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_cold_q <= `PMCAP_RST_WAKE_COLD;
         wake_d2_q   <= `PMCAP_RST_WAKE_D2;
         state_two_q <= `PMCAP_RST_STATE_TWO;
      end else begin
         wake_cold_q <= wake_cold_d;
         wake_d2_q   <= wake_d2_d;
         state_two_q <= state_two_d;
      end
   end

   // Assemble the report from mirrored and fixed fields
   always_comb begin
      caps_w = '0;
      caps_w.wake_from_cold_capable   = wake_cold_q;
      // Hot-off fixed on, state two follows misc, low bits fixed off
      caps_w.wake_source_states = {`PMCAP_WAKE_HOT_FIXED, wake_d2_q,
                                   `PMCAP_WAKE_LOW_FIXED};
      caps_w.state_two_supported      = state_two_q;
      caps_w.state_one_supported      = `PMCAP_STATE_ONE_FIXED;
      caps_w.dynamic_power_report     = `PMCAP_DYN_REPORT_FIXED;
      caps_w.reserved                 = `PMCAP_RSVD_FIXED;
      caps_w.device_init_needed       = `PMCAP_DEV_INIT_FIXED;
      caps_w.auxiliary_supply_needed  = `PMCAP_AUX_SUPPLY_FIXED;
      caps_w.wake_needs_bus_clock     = `PMCAP_BUS_CLOCK_FIXED;
      caps_w.power_interface_revision = `PMCAP_REVISION_FIXED;
   end

   assign caps_flat = caps_w;
   assign caps      = caps_w;

   // Offset decode and registered read data
   pmcap_cfg_port #(
      .ADDR_W (8),
      .DATA_W (16),
      .OFFSET (`PMCAP_REPORT_OFFSET)
   ) u_port (
      .clk       (clk),
      .rst_n     (rst_n),
      .addr      (cfg_req.addr),
      .rd        (cfg_req.rd),
      .wr        (cfg_req.wr),
      .reg_value (caps_flat),
      .hit_wr    (hit_wr),
      .rdata     (cfg_rdata)
   );

   // Dropped host write, reported one cycle later for debug
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         write_ignored_q <= 1'b0;
      end else begin
         write_ignored_q <= hit_wr;
      end
   end

   assign write_ignored = write_ignored_q;

   // Report-offset strobes, read only by the checks below
   assign rd_hit = cfg_req.rd && (cfg_req.addr == `PMCAP_REPORT_OFFSET);
   assign wr_hit = cfg_req.wr && (cfg_req.addr == `PMCAP_REPORT_OFFSET);

   // Records the first misc update so reset-value checks know when to stop
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         loaded_q <= 1'b0;
      end else if (misc_update) begin
         loaded_q <= 1'b1;
      end
   end

   // Cold-off wake bit copies misc bit 15 one cycle after an update
   a_cold_wake_mirror: assert property (
      @(posedge clk) disable iff (!rst_n)
      misc_update |=> caps.wake_from_cold_capable == $past(misc_cfg[`PMCAP_MISC_WAKE_COLD])
   ) else $error("cold wake bit did not follow misc bit 15");

   // Wake-state field keeps hot-off set and the two low bits clear
   a_wake_field_fixed: assert property (
      @(posedge clk) disable iff (!rst_n)
      caps.wake_source_states[3] == 1'b1 && caps.wake_source_states[1:0] == 2'h0
   ) else $error("wake state field fixed bits wrong");

   // Wake-from-two bit copies misc bit 13 after an update
   a_d2_wake_follow: assert property (
      @(posedge clk) disable iff (!rst_n)
      misc_update |=> caps.wake_source_states[2] == $past(misc_cfg[`PMCAP_MISC_WAKE_D2])
   ) else $error("state two wake bit did not follow misc bit 13");

   // State-two support bit copies misc bit 10 after an update
   a_state_two_supported_mirror: assert property (
      @(posedge clk) disable iff (!rst_n)
      misc_update |=> caps.state_two_supported == $past(misc_cfg[`PMCAP_MISC_STATE_TWO])
   ) else $error("state two support bit did not follow misc bit 10");

   // Without an update the mirrored bits hold for two cycles
   a_mirror_hold: assert property (
      @(posedge clk) disable iff (!rst_n)
      !misc_update ##1 !misc_update |->
         $stable(caps.wake_from_cold_capable) && $stable(caps.state_two_supported)
         && $stable(caps.wake_source_states)
   ) else $error("mirrored bits changed without a misc update");

   // State one never advertised, seen on the read port too
   a_state_one_zero: assert property (
      @(posedge clk) disable iff (!rst_n)
      (cfg_req.rd && cfg_req.addr == `PMCAP_REPORT_OFFSET) |=> cfg_rdata[9] == 1'b0
   ) else $error("state one support read as set");

   // Dynamic power data never advertised
   a_dyn_report_zero: assert property (
      @(posedge clk) disable iff (!rst_n)
      (cfg_req.rd && cfg_req.addr == `PMCAP_REPORT_OFFSET) |=> cfg_rdata[8] == 1'b0
   ) else $error("dynamic power bit read as set");

   // Reserved pair reads zero
   a_reserved_zero: assert property (
      @(posedge clk) disable iff (!rst_n)
      (cfg_req.rd && cfg_req.addr == `PMCAP_REPORT_OFFSET) |=> cfg_rdata[7:6] == 2'h0
   ) else $error("reserved bits read as nonzero");

   // No device-specific initialization advertised
   a_dev_init_zero: assert property (
      @(posedge clk) disable iff (!rst_n)
      caps.device_init_needed == 1'b0
   ) else $error("device init bit set");

   // Auxiliary supply always needed, also on the read port
   a_aux_supply_one: assert property (
      @(posedge clk) disable iff (!rst_n)
      (cfg_req.rd && cfg_req.addr == `PMCAP_REPORT_OFFSET) |=> cfg_rdata[4] == 1'b1
   ) else $error("auxiliary supply bit read as clear");

   // No bus clock needed for wake
   a_bus_clock_zero: assert property (
      @(posedge clk) disable iff (!rst_n)
      caps.wake_needs_bus_clock == 1'b0
   ) else $error("bus clock bit set");

   // Revision code on the read port
   a_revision_code: assert property (
      @(posedge clk) disable iff (!rst_n)
      (cfg_req.rd && cfg_req.addr == `PMCAP_REPORT_OFFSET) |=> cfg_rdata[2:0] == 3'h1
   ) else $error("revision field not 001b");

   // Before any misc update the report reads its reset value
   a_reset_value: assert property (
      @(posedge clk) disable iff (!rst_n)
      (!loaded_q && !misc_update && cfg_req.rd && cfg_req.addr == `PMCAP_REPORT_OFFSET)
         |=> cfg_rdata == `PMCAP_REPORT_RESET
   ) else $error("report not 6411h before first update");

   // A read elsewhere returns zero, and data stand only one cycle
   a_read_decode: assert property (
      @(posedge clk) disable iff (!rst_n)
      !(cfg_req.rd && cfg_req.addr == `PMCAP_REPORT_OFFSET) |=> cfg_rdata == 16'h0000
   ) else $error("read data nonzero outside a report read");

   // A host write alone changes nothing in the report
   a_write_ignored: assert property (
      @(posedge clk) disable iff (!rst_n)
      (wr_hit && !misc_update) |=> $stable(caps) && write_ignored
   ) else $error("host write altered the report");

   // Cold-off wake bit reaches the read port unchanged
   a_cold_read_back: assert property (
      @(posedge clk) disable iff (!rst_n)
      rd_hit |=> cfg_rdata[`PMCAP_BIT_WAKE_COLD] == $past(caps.wake_from_cold_capable)
   ) else $error("cold wake bit differs on the read port");

   // Hot-off wake bit reads as set
   a_hot_wake_read: assert property (
      @(posedge clk) disable iff (!rst_n)
      rd_hit |=> cfg_rdata[`PMCAP_BIT_WAKE_HOT] == `PMCAP_WAKE_HOT_FIXED
   ) else $error("hot wake bit read as clear");

   // Two low wake-state bits read as clear
   a_low_wake_read: assert property (
      @(posedge clk) disable iff (!rst_n)
      rd_hit |=> cfg_rdata[12:11] == `PMCAP_WAKE_LOW_FIXED
   ) else $error("low wake state bits read as set");

   // Wake-from-two bit reaches the read port unchanged
   a_d2_wake_read: assert property (
      @(posedge clk) disable iff (!rst_n)
      rd_hit |=> cfg_rdata[`PMCAP_BIT_WAKE_D2] == $past(caps.wake_source_states[2])
   ) else $error("state two wake bit differs on the read port");

   // State-two support bit reaches the read port unchanged
   a_state_two_supported_read: assert property (
      @(posedge clk) disable iff (!rst_n)
      rd_hit |=> cfg_rdata[`PMCAP_BIT_STATE_TWO] == $past(caps.state_two_supported)
   ) else $error("state two support bit differs on the read port");

   // All three mirrored bits take the loaded image together
   a_update_takes_image: assert property (
      @(posedge clk) disable iff (!rst_n)
      misc_update |=> {caps.wake_from_cold_capable, caps.wake_source_states[2],
         caps.state_two_supported} == $past({misc_cfg[`PMCAP_MISC_WAKE_COLD],
         misc_cfg[`PMCAP_MISC_WAKE_D2], misc_cfg[`PMCAP_MISC_STATE_TWO]})
   ) else $error("mirrored bits did not take the loaded image");

   // A loaded image stays put once the pulse has gone
   a_update_then_hold: assert property (
      @(posedge clk) disable iff (!rst_n)
      misc_update ##1 !misc_update |=> $stable(caps)
   ) else $error("report moved after the update pulse ended");

   // State one never advertised in the live fields
   a_state_one_caps: assert property (
      @(posedge clk) disable iff (!rst_n)
      caps.state_one_supported == `PMCAP_STATE_ONE_FIXED
   ) else $error("state one support field set");

   // Dynamic power data never advertised in the live fields
   a_dyn_report_caps: assert property (
      @(posedge clk) disable iff (!rst_n)
      caps.dynamic_power_report == `PMCAP_DYN_REPORT_FIXED
   ) else $error("dynamic power field set");

   // Reserved pair clear in the live fields
   a_reserved_caps: assert property (
      @(posedge clk) disable iff (!rst_n)
      caps.reserved == `PMCAP_RSVD_FIXED
   ) else $error("reserved field nonzero");

   // No device-specific initialization seen on the read port
   a_dev_init_read: assert property (
      @(posedge clk) disable iff (!rst_n)
      rd_hit |=> cfg_rdata[`PMCAP_BIT_DEV_INIT] == `PMCAP_DEV_INIT_FIXED
   ) else $error("device init bit read as set");

   // Auxiliary supply flag set in the live fields
   a_aux_supply_caps: assert property (
      @(posedge clk) disable iff (!rst_n)
      caps.auxiliary_supply_needed == `PMCAP_AUX_SUPPLY_FIXED
   ) else $error("auxiliary supply field clear");

   // No bus clock needed, seen on the read port
   a_bus_clock_read: assert property (
      @(posedge clk) disable iff (!rst_n)
      rd_hit |=> cfg_rdata[`PMCAP_BIT_BUS_CLOCK] == `PMCAP_BUS_CLOCK_FIXED
   ) else $error("bus clock bit read as set");

   // Revision code in the live fields
   a_revision_caps: assert property (
      @(posedge clk) disable iff (!rst_n)
      caps.power_interface_revision == `PMCAP_REVISION_FIXED
   ) else $error("revision field wrong in live fields");

   // Live fields hold the reset value until the first load
   a_reset_fields: assert property (
      @(posedge clk) disable iff (!rst_n)
      !loaded_q |-> caps == `PMCAP_REPORT_RESET
   ) else $error("live fields not at reset value before first load");

   // A report read returns the whole report of the strobe cycle
   a_read_back_whole: assert property (
      @(posedge clk) disable iff (!rst_n)
      rd_hit |=> cfg_rdata == $past(caps_flat)
   ) else $error("read data differ from the report");

   // No notice without a write to the report offset
   a_write_notice_pulse: assert property (
      @(posedge clk) disable iff (!rst_n)
      !wr_hit |=> !write_ignored
   ) else $error("write notice without a report write");

   // A write to any offset leaves the report alone
   a_other_write_quiet: assert property (
      @(posedge clk) disable iff (!rst_n)
      (cfg_req.wr && !misc_update) |=> $stable(caps)
   ) else $error("write to another offset altered the report");

   // Every notice traces back to a report write
   a_notice_from_hit: assert property (
      @(posedge clk) disable iff (!rst_n)
      write_ignored |-> $past(wr_hit)
   ) else $error("write notice with no write before it");

endmodule

// *** bench/pmcap_misc_model.sv ***
// Behavioural source of the miscellaneous register that feeds the capability report
`timescale 1ns/1ps

module pmcap_misc_model #(
   parameter logic [15:0] MISC_RESET = 16'h2400   // Loader default: bits 13 and 10 set
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        load_req,
   input  wire logic [15:0] load_value,
   output logic [15:0]      misc_cfg,
   output logic             misc_update
);

   // Register image; a load or host rewrite lands here together with one update pulse
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         misc_cfg    <= MISC_RESET;    // Image before any load
         misc_update <= 1'b0;          // No pulse in reset
      end else begin
         misc_update <= load_req;      // One pulse for each load
         if (load_req) begin
            misc_cfg <= load_value;    // New image travels with the pulse
         end
      end
   end

endmodule

// *** bench/pmcap_report_tb.sv ***
// Self-checking bench for the capability report and its configuration port
`timescale 1ns/1ps

module pmcap_report_tb;
   import pmcap_pkg::*;

   localparam pmcap_req_t REQ_IDLE = '{addr: 8'h00, wdata: 16'h0000, wr: 1'b0, rd: 1'b0};

   logic        clk;             // Bus clock
   logic        rst_n;           // Async reset, active low
   pmcap_req_t  cfg_req;         // Configuration request
   logic [15:0] cfg_rdata;       // Read data, cycle after strobe
   logic [15:0] misc_cfg;        // Misc register image from the model
   logic        misc_update;     // Misc load pulse from the model
   pmcap_caps_t caps;            // Live report fields
   logic        write_ignored;   // Notice of a dropped write
   logic        load_req;        // Bench asks the model for a load
   logic [15:0] load_value;      // Value to load
   logic [15:0] rd_val;          // Last read result
   logic        ign;             // Last write notice
   int          bad_count;       // Mismatches
   int          num_checks;      // Comparisons made
   int          cycle_count;     // Cycles since start
   logic [15:0] misc_vals [7] = '{16'h8000, 16'h0000, 16'ha400, 16'hffff,
                                  16'h2000, 16'h0400, 16'h2400};
   logic [7:0]  void_offs [4] = '{8'h44, 8'h48, 8'h47, 8'hf0};

   // Device under test
   pmcap_report dut (
      .clk           (clk),
      .rst_n         (rst_n),
      .cfg_req       (cfg_req),
      .cfg_rdata     (cfg_rdata),
      .misc_cfg      (misc_cfg),
      .misc_update   (misc_update),
      .caps          (caps),
      .write_ignored (write_ignored)
   );

   // Far-side misc register source
   pmcap_misc_model u_misc (
      .clk         (clk),
      .rst_n       (rst_n),
      .load_req    (load_req),
      .load_value  (load_value),
      .misc_cfg    (misc_cfg),
      .misc_update (misc_update)
   );

   // Expected report for a given misc image; fixed fields written out bit by bit
   function automatic logic [15:0] report_of(input logic [15:0] misc);
      return {misc[15], 1'b1, misc[13], 2'b00, misc[10], 2'b00, 2'b00,
              1'b0, 1'b1, 1'b0, 3'b001};
   endfunction

   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Verdict and end of run
   task automatic report_and_stop();
      if (bad_count == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // One-cycle read; data taken in the cycle after the strobe
   task automatic cfg_read(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      cfg_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      cfg_req <= REQ_IDLE;
      #1 d = cfg_rdata;
   endtask

   // One-cycle write; notice taken in the cycle after the strobe
   task automatic cfg_write(input logic [7:0] a, input logic [15:0] v, output logic n);
      @(posedge clk);
      cfg_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      cfg_req <= REQ_IDLE;
      #1 n = write_ignored;
   endtask

   // Read and compare
   task automatic expect_read(input logic [7:0] a, input logic [15:0] exp);
      cfg_read(a, rd_val);
      check(rd_val, exp);
   endtask

   // Misc load through the model; returns once the report has taken it
   task automatic misc_load(input logic [15:0] v);
      @(posedge clk);
      load_req   <= 1'b1;
      load_value <= v;
      @(posedge clk);
      load_req <= 1'b0;
      @(posedge clk);
      #1;
   endtask

   // Reset held for eight cycles
   task automatic do_reset();
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
   endtask

   // Clock, 4 ns period
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Hang guard
   initial begin
      cycle_count = 0;
   end
   always @(posedge clk) begin
      cycle_count++;
      if (cycle_count == 3000) begin
         bad_count++;
         report_and_stop();
      end
   end

   // Main sequence
   initial begin
      rst_n      = 1'b0;
      cfg_req    = REQ_IDLE;
      load_req   = 1'b0;
      load_value = 16'h0000;
      bad_count  = 0;
      num_checks = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      #1 check(caps, 16'h6411);
      expect_read(8'h46, 16'h6411);
      @(posedge clk);
      #1 check(cfg_rdata, 16'h0000);
      // Neighbouring and unmapped offsets return nothing
      foreach (void_offs[i]) begin
         expect_read(void_offs[i], 16'h0000);
      end
      // Writes are dropped, only the report offset gives the notice
      cfg_write(8'h46, 16'hffff, ign);
      check({15'h0000, ign}, 16'h0001);
      cfg_write(8'h46, 16'h0000, ign);
      check({15'h0000, ign}, 16'h0001);
      expect_read(8'h46, 16'h6411);
      cfg_write(8'h48, 16'hffff, ign);
      check({15'h0000, ign}, 16'h0000);
      // Misc images: mirrored bits follow, fixed bits never move
      foreach (misc_vals[i]) begin
         misc_load(misc_vals[i]);
         check(caps, report_of(misc_vals[i]));
         expect_read(8'h46, report_of(misc_vals[i]));
      end
      // Read in the same cycle as the update pulse sees the old image
      @(posedge clk);
      load_req   <= 1'b1;
      load_value <= 16'h8000;
      @(posedge clk);
      load_req <= 1'b0;
      cfg_req  <= '{addr: 8'h46, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      cfg_req <= REQ_IDLE;
      #1 check(cfg_rdata, report_of(16'h2400));
      expect_read(8'h46, 16'hc011);
      // A host write cannot undo the loaded image
      cfg_write(8'h46, 16'h6411, ign);
      expect_read(8'h46, 16'hc011);
      // Second reset in mid-run restores the default
      do_reset();
      #1 check(caps, 16'h6411);
      expect_read(8'h46, 16'h6411);
      report_and_stop();
   end

endmodule
